// [logic/tpts_pkg.sv]
package tpts_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PADS   = 8;
  localparam int unsigned PAD_W      = 3;
  localparam int unsigned COL_W      = 3;
  localparam int unsigned CMP_W      = 8;
  localparam int unsigned SLICE_W    = 16;
  // ---------------------------------------------------------------
  // Previous-function codes
  // ---------------------------------------------------------------
  localparam logic [COL_W-1:0] PREV_FUNCTION_COLUMN_TOUCH = 3'h7;
  localparam logic [COL_W-1:0] PREV_FUNCTION_COLUMN_COL0  = 3'h6;
  // ---------------------------------------------------------------
  // Timing and reset values
  // ---------------------------------------------------------------
  localparam int unsigned SLICE_NS   = 25600;
  localparam int unsigned CLK_NS     = 25;
  localparam int unsigned SLICE_CYC  = SLICE_NS / CLK_NS;
  localparam logic [PAD_W-1:0]   PAD_RST   = 3'h0;
  localparam logic [CMP_W-1:0]   CMP_RST   = 8'h00;
  localparam logic [COL_W-1:0]   PREV_FUNCTION_COLUMN_RST = 3'h7;
  localparam logic [SLICE_W-1:0] CNT_RST   = 16'h0000;
endpackage

// [logic/tpts_slice_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tpts_slice_timer
  import tpts_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Control
  input  wire logic run_in,
  // Slice boundary pulse
  output var  logic slice_end_out
);
  typedef struct packed {
    logic [SLICE_W-1:0] cnt;
    logic               tick;
  } tpts_tmr_s;
  tpts_tmr_s st_q, st_d;
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!run_in) begin
      st_d.cnt = CNT_RST;
    end else if (st_q.cnt == SLICE_W'(SLICE_CYC - 1)) begin
      st_d.cnt  = CNT_RST;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign slice_end_out = st_q.tick;
endmodule // tpts_slice_timer
`default_nettype wire

// [logic/tpts_turn_sequencer.sv]
// How it works
// RL1: Pad-turn index updates one full slice after the touch slice ends.
// RL2: Each touch slice start loads compare register from indexed pad value; the first touch slice after reset or enable keeps the old value.
// RL3: Under two columns the late update loads the previous pad's value.
// RL4: With no columns, pad 0 holds one extra slice before advancing.
// RL5: Two or more columns hide the delay; correct value is loaded.
// RL6: Late update only with hardware turn control and touch enabled.
// RL7: Index read at frame interrupt gives the currently active pad.
// RL8: Previous-function code 111/110 touch or column 0, 101..000 later columns.
// RL9: Slice-interrupt reads after touch or first column give previous pad.
// RL10: In software mode the index only changes by software writes.
// RL11: Software rewrites the preceding pad's slot each frame as fix.
// RL12: Or software preloads all slots shifted by one position.
// RL13: Hardware index advances one pad per touch slice, wrapping.
// RL14: Slice interrupt each slice end; frame interrupt each frame end.
`timescale 1ns/1ps
`default_nettype none
module tpts_turn_sequencer
  import tpts_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  // Configuration
  input  wire logic                    touch_sense_enable_in,
  input  wire logic                    pad_turn_sw_select_in,
  input  wire logic [COL_W-1:0]        led_columns_in,
  input  wire logic [PAD_W-1:0]        max_pad_in,
  // Software index write
  input  wire logic                    pad_turn_wr_in,
  input  wire logic [PAD_W-1:0]        pad_turn_wdata_in,
  // Per-pad compare values, pad 0 in low bits
  input  wire logic [NUM_PADS*CMP_W-1:0] pad_compare_value_in,
  // Status
  output var  logic [PAD_W-1:0]        pad_turn_index_out,
  output var  logic [COL_W-1:0]        prev_function_column_out,
  output var  logic [CMP_W-1:0]        internal_compare_out,
  output var  logic                    touch_sense_slice_out,
  output var  logic [COL_W-1:0]        slice_number_out,
  // Events
  output var  logic                    slice_irq_out,
  output var  logic                    frame_irq_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PAD_W-1:0] pad;
    logic             adv_pend;
    logic             adv_now;
    logic [COL_W-1:0] slot;
    logic [COL_W-1:0] prev_function_column;
    logic [CMP_W-1:0] cmp;
    logic             slice_irq;
    logic             frame_irq;
    logic             ts_slice;
  } tpts_st_s;

  tpts_st_s st_q, st_d;
  logic     slice_end;
  logic     hw_mode;

  function automatic logic [CMP_W-1:0] pick_cmp(
    input logic [NUM_PADS*CMP_W-1:0] v,
    input logic [PAD_W-1:0]          p
  );
    pick_cmp = v[p*CMP_W +: CMP_W];
  endfunction

  function automatic logic [PAD_W-1:0] next_pad(
    input logic [PAD_W-1:0] p,
    input logic [PAD_W-1:0] top
  );
    next_pad = (p >= top) ? PAD_RST : p + 3'h1;
  endfunction

  assign hw_mode = touch_sense_enable_in && !pad_turn_sw_select_in;

  tpts_slice_timer u_timer (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .run_in        (touch_sense_enable_in),
    .slice_end_out (slice_end)
  );

  // ---------------------------------------------------------------
  // Slice sequencing
  // ---------------------------------------------------------------
  // Slot 0 is the touch slice, slots 1..N are LED columns.
  always_comb begin
    st_d           = st_q;
    st_d.slice_irq = 1'b0;
    st_d.frame_irq = 1'b0;
    st_d.adv_now   = 1'b0;
    if (!touch_sense_enable_in) begin
      st_d.slot     = '0;
      st_d.adv_pend = 1'b0;
    end else if (slice_end) begin
      st_d.slice_irq = 1'b1;                               // [RL14]
      // Code of the slice just ended: 111 touch, then 110 downward
      st_d.prev_function_column = (st_q.slot == '0) ? PREV_FUNCTION_COLUMN_TOUCH
                 : PREV_FUNCTION_COLUMN_TOUCH - st_q.slot;                // [RL8]
      // Advance is armed at touch end and fires one slice later
      st_d.adv_now  = st_q.adv_pend;                       // [RL1]
      st_d.adv_pend = (st_q.slot == '0) && hw_mode;        // [RL6]
      if (st_q.slot >= led_columns_in) begin
        st_d.slot      = '0;
        st_d.frame_irq = 1'b1;                             // [RL14]
      end else begin
        st_d.slot = st_q.slot + 3'h1;
      end
      // Compare loaded from index as it stands now; with <2 columns
      // the pending advance has not happened yet, so the old pad's
      // value is taken, and with 0 columns pad 0 lingers a slice.
      if (st_d.slot == '0) begin
        st_d.cmp = pick_cmp(pad_compare_value_in, st_q.pad); // [RL2] [RL3] [RL4]
      end
    end
    // Registered so the touch-slice flag comes straight from a flop
    st_d.ts_slice = touch_sense_enable_in && (st_d.slot == '0);
    // Index update, one slice after the touch slice ended
    if (st_q.adv_now && hw_mode) begin
      st_d.pad = next_pad(st_q.pad, max_pad_in);           // [RL13] [RL5]
    end
    if (pad_turn_sw_select_in && pad_turn_wr_in) begin
      st_d.pad = pad_turn_wdata_in;                        // [RL10]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q       <= '0;
      st_q.prev_function_column <= PREV_FUNCTION_COLUMN_RST;
      st_q.cmp   <= CMP_RST;
      st_q.pad   <= PAD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Index reads straight from the register, so interrupt-time reads
  // naturally show the lag described by the previous-function code.
  always_comb begin
    pad_turn_index_out       = st_q.pad;                   // [RL7] [RL9]
    prev_function_column_out = st_q.prev_function_column;
    internal_compare_out     = st_q.cmp;
    touch_sense_slice_out    = st_q.ts_slice;
    slice_number_out         = st_q.slot;
    slice_irq_out            = st_q.slice_irq;
    frame_irq_out            = st_q.frame_irq;
  end
endmodule // tpts_turn_sequencer
`default_nettype wire

// [tb/touch_pad_turn_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module touch_pad_turn_sequencer_bench
  import tpts_pkg::*;
;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, touch_sense_enable_in = 1'b0;
  logic pad_turn_sw_select_in = 1'b0, pad_turn_wr_in = 1'b0;
  logic [COL_W-1:0] led_columns_in = 3'h0, prev_function_column_out;
  logic [COL_W-1:0] slice_number_out;
  logic [PAD_W-1:0] max_pad_in = 3'h2, pad_turn_wdata_in = 3'h0;
  logic [PAD_W-1:0] pad_turn_index_out;
  logic [NUM_PADS*CMP_W-1:0] pad_compare_value_in;
  logic [CMP_W-1:0] internal_compare_out;
  logic touch_sense_slice_out, slice_irq_out, frame_irq_out;
  logic shift_table = 1'b0;
  int n_fail = 0;
  int n_checks = 0;
  always #12.5 clk_in = ~clk_in;
  tpts_pad_model model (.shift_in(shift_table), .top_in(max_pad_in),
    .pad_compare_value_out(pad_compare_value_in));
  tpts_turn_sequencer uut (.*);
  task finish_test;
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Columns and turn mode only change under reset, so no slice is cut short
  task do_reset(input int n, input logic s, input logic e);
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    led_columns_in <= 3'(n);
    pad_turn_sw_select_in <= s;
    touch_sense_enable_in <= e;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask
  task wait_frame;
    for (int i = 0; i < 9000; i++) begin
      @(negedge clk_in);
      if (frame_irq_out === 1'b1) return;
    end
    n_fail++;
    finish_test;
  endtask
  task check_hw(input int n);
    int e;
    do_reset(n, 1'b0, 1'b1);
    for (int k = 1; k <= 6; k++) begin
      wait_frame;
      e = k - (n < 2) - (n == 0 && k > 1);
      `CHK(internal_compare_out, 8'h50 + 8'(e % 3))
      `CHK(touch_sense_slice_out, 1'b1)
      @(negedge clk_in);
      `CHK(pad_turn_index_out, 3'((k - (n == 0)) % 3))
    end
  endtask
  task check_shift;
    shift_table <= 1'b1;
    do_reset(1, 1'b0, 1'b1);
    for (int k = 1; k <= 3; k++) begin
      wait_frame;
      `CHK(internal_compare_out, 8'h50 + 8'(k % 3))
    end
    shift_table <= 1'b0;
  endtask
  task check_sw;
    do_reset(0, 1'b1, 1'b0);
    repeat (1100) @(negedge clk_in);
    `CHK(pad_turn_index_out, 3'h0)
    `CHK(touch_sense_slice_out, 1'b0)
    @(posedge clk_in);
    touch_sense_enable_in <= 1'b1;
    pad_turn_wr_in <= 1'b1;
    pad_turn_wdata_in <= 3'h5;
    @(posedge clk_in);
    pad_turn_wr_in <= 1'b0;
    repeat (3) wait_frame;
    `CHK(internal_compare_out, 8'h55)
    `CHK(pad_turn_index_out, 3'h5)
  endtask
  initial begin
    check_hw(0);
    check_hw(1);
    check_hw(3);
    check_shift;
    check_sw;
    finish_test;
  end
endmodule // touch_pad_turn_sequencer_bench
`default_nettype wire

// [tb/tpts_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tpts_assertions
  import tpts_pkg::*;
(
  // Clock, reset, controls and status
  input wire logic             clk_in, sys_rst_in, touch_sense_enable_in,
  input wire logic             pad_turn_sw_select_in, pad_turn_wr_in,
  input wire logic [COL_W-1:0] led_columns_in, prev_function_column_out,
  input wire logic [COL_W-1:0] slice_number_out,
  input wire logic [PAD_W-1:0] pad_turn_wdata_in, pad_turn_index_out,
  // Results
  input wire logic [CMP_W-1:0] internal_compare_out,
  input wire logic             slice_irq_out, frame_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_irq_one_cycle: assert property (
    slice_irq_out |=> !slice_irq_out) else $error("slice pulse long");
  a_frame_at_wrap: assert property (
    slice_irq_out |-> frame_irq_out == (slice_number_out == 3'h0))
    else $error("frame pulse off wrap");
  a_slot_order: assert property (
    slice_irq_out |-> slice_number_out == (($past(slice_number_out)
    == led_columns_in) ? 3'h0 : $past(slice_number_out) + 3'h1))
    else $error("slot order");
  a_prev_function_column_code: assert property (
    slice_irq_out |-> prev_function_column_out
    == 3'h7 - $past(slice_number_out)) else $error("column code");
  a_cmp_at_touch: assert property (
    $changed(internal_compare_out) |-> slice_irq_out
    && slice_number_out == 3'h0) else $error("compare load off slot");
  a_sw_write_shows: assert property (
    pad_turn_sw_select_in && pad_turn_wr_in
    |=> pad_turn_index_out == $past(pad_turn_wdata_in))
    else $error("index write lost");
  a_index_held: assert property (
    (pad_turn_sw_select_in || !touch_sense_enable_in) && !pad_turn_wr_in
    |=> $stable(pad_turn_index_out)) else $error("index moved");
  a_late_advance: assert property (
    !pad_turn_sw_select_in && $changed(pad_turn_index_out)
    |-> $past(slice_irq_out) && ($past(prev_function_column_out)
    == PREV_FUNCTION_COLUMN_COL0 || led_columns_in == 3'h0)) else $error("early index");
  c_frame: cover property (frame_irq_out);
  c_write: cover property (pad_turn_sw_select_in && pad_turn_wr_in);
  c_advance: cover property ($changed(pad_turn_index_out));
endmodule // tpts_assertions
bind tpts_turn_sequencer tpts_assertions u_chk (.*);
`default_nettype wire

// [tb/tpts_pad_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpts_pad_model
  import tpts_pkg::*;
(
  // Software table layout
  input  wire logic                      shift_in,
  input  wire logic [PAD_W-1:0]          top_in,
  // Window per pad, distinct so a wrong pick shows
  output var  logic [NUM_PADS*CMP_W-1:0] pad_compare_value_out
);
  // Shifted table: slot k below top holds pad k+1's window, top slot and above pad 0's,
  // the same contents the per-frame rewrite leaves behind
  always_comb
    for (int k = 0; k < NUM_PADS; k++)
      pad_compare_value_out[k*CMP_W +: CMP_W] = 8'h50 + (shift_in ?
        ((PAD_W'(k) >= top_in) ? 8'h00 : 8'(k + 1)) : 8'(k));
endmodule // tpts_pad_model
`default_nettype wire
